//--- design/bfc_pkg.sv
// package: register layout, reset value, timing and carrier types for the buck4 control block
package bfc_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] REG_OFFSET = 8'h44;
	localparam logic [7:0] REG_RESET = 8'hA0;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int BIT_FAULT_MASK = 7;
	localparam int BIT_HICCUP = 6;
	localparam int BIT_DISCHARGE = 5;
	localparam int BIT_PHASE = 4;
	localparam int BIT_RATE_HI = 3;
	localparam int BIT_RATE_LO = 2;
	localparam int BIT_REG_EN = 1;
	localparam int BIT_OVERRIDE = 0;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int RESTART_DELAY_MS = 100;
	localparam int RESTART_CYCLES = (RESTART_DELAY_MS * 1000000) / CLK_PERIOD_NS;
	// ----------------------------------------
	// carrier types
	// ----------------------------------------
	typedef struct packed {
		logic fault_irq_mask;
		logic hiccup_retry_enable;
		logic discharge_enable;
		logic phase_invert;
		logic [1:0] voltage_scaling_rate;
		logic register_enable;
		logic register_on_override;
	} bfc_ctrl_s;
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} bfc_wr_s;
	typedef enum logic [1:0] {
		ST_RUN,
		ST_HICCUP,
		ST_SHUTDOWN
	} bfc_state_e;
endpackage : bfc_pkg

//--- design/bfc_counter.sv
// file: loadable down-counter used for the restart delay
`timescale 1ns/1ps
module bfc_counter #(
	parameter int W = 24
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// control
	input wire logic load,
	input wire logic [W-1:0] load_val,
	// status
	output logic done
);
	logic [W-1:0] cnt_q;
	logic run_q;

	assign done = run_q && (cnt_q == '0);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
			run_q <= 1'b0;
		end else if (load) begin
			cnt_q <= load_val;
			run_q <= 1'b1;
		end else if (run_q && cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end else begin
			run_q <= 1'b0;
		end
	end
endmodule : bfc_counter

//--- design/bfc_top.sv
// file: buck4 fault and control register with channel fault reaction
//
// Contract
// - fault mask blocks low interrupt on fault
// - hiccup set: short retries soft start forever
// - hiccup keeps other channels running
// - hiccup clear: all off, restart after 100ms
// - phase bit selects 180 degree switching
// - override set: register enable drives channel
// - override clear: register enable ignored
`timescale 1ns/1ps
module bfc_top #(
	parameter int RESTART_CYCLES = bfc_pkg::RESTART_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// register access from the management link decoder
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// channel status from analogue
	input wire logic short_circuit,
	input wire logic seq_enable,
	input wire logic soft_start_done,
	// channel controls
	output logic chan_on,
	output logic soft_start_req,
	output logic discharge_on,
	output logic phase_180,
	output logic [1:0] scaling_rate,
	output logic all_channels_off,
	output logic restart_seq,
	output logic channel_fault_flag,
	output logic interrupt_out_n
);
	// ----------------------------------------
	// register
	// ----------------------------------------
	bfc_pkg::bfc_ctrl_s ctrl_q;
	bfc_pkg::bfc_wr_s wr_req;
	bfc_pkg::bfc_state_e state_q;
	bfc_pkg::bfc_state_e state_d;
	wire addr_hit;
	wire want_on;
	wire sc_hiccup;
	wire sc_global;
	wire delay_done;
	logic fault_q;

	assign wr_req = '{wr: reg_wr, addr: reg_addr, wdata: reg_wdata};
	assign addr_hit = wr_req.addr == bfc_pkg::REG_OFFSET;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ctrl_q <= bfc_pkg::REG_RESET;
		end else if (wr_req.wr && addr_hit) begin
			ctrl_q <= wr_req.wdata;
		end
	end

	// ----------------------------------------
	// enable source
	// ----------------------------------------
	// override picks register enable; else the sequencer decides
	assign want_on = ctrl_q.register_on_override ? ctrl_q.register_enable : seq_enable;
	assign sc_hiccup = short_circuit && ctrl_q.hiccup_retry_enable && state_q == bfc_pkg::ST_RUN;
	assign sc_global = short_circuit && !ctrl_q.hiccup_retry_enable && state_q != bfc_pkg::ST_SHUTDOWN;

	// ----------------------------------------
	// fault state machine
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			bfc_pkg::ST_RUN: begin
				if (sc_global) state_d = bfc_pkg::ST_SHUTDOWN;
				else if (sc_hiccup) state_d = bfc_pkg::ST_HICCUP;
			end
			bfc_pkg::ST_HICCUP: begin
				// no retry limit: stays here while the short persists
				if (sc_global) state_d = bfc_pkg::ST_SHUTDOWN;
				else if (soft_start_done && !short_circuit) state_d = bfc_pkg::ST_RUN;
			end
			bfc_pkg::ST_SHUTDOWN: begin
				if (delay_done) state_d = bfc_pkg::ST_RUN;
			end
			default: state_d = bfc_pkg::ST_RUN;
		endcase
	end

	bfc_counter #(.W(24)) u_delay (
		.mclk(mclk),
		.rst(rst),
		.load(sc_global),
		.load_val(24'(RESTART_CYCLES - 1)),
		.done(delay_done)
	);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_q <= bfc_pkg::ST_RUN;
			fault_q <= 1'b0;
		end else begin
			state_q <= state_d;
			fault_q <= short_circuit || (fault_q && state_q != bfc_pkg::ST_RUN);
		end
	end

	// ----------------------------------------
	// outputs, all registered
	// ----------------------------------------
	wire on_d = want_on && state_d == bfc_pkg::ST_RUN;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			chan_on <= 1'b0;
			soft_start_req <= 1'b0;
			discharge_on <= 1'b0;
			phase_180 <= 1'b0;
			scaling_rate <= 2'h0;
			all_channels_off <= 1'b0;
			restart_seq <= 1'b0;
			channel_fault_flag <= 1'b0;
			interrupt_out_n <= 1'b1;
			reg_rdata <= 8'h00;
		end else begin
			chan_on <= on_d;
			// hiccup retries soft start on this channel only
			soft_start_req <= state_d == bfc_pkg::ST_HICCUP && want_on;
			discharge_on <= ctrl_q.discharge_enable && !on_d;
			phase_180 <= ctrl_q.phase_invert;
			scaling_rate <= ctrl_q.voltage_scaling_rate;
			all_channels_off <= state_d == bfc_pkg::ST_SHUTDOWN;
			restart_seq <= state_q == bfc_pkg::ST_SHUTDOWN && delay_done;
			channel_fault_flag <= fault_q;
			interrupt_out_n <= !(fault_q && !ctrl_q.fault_irq_mask);
			reg_rdata <= addr_hit ? ctrl_q : 8'h00;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_global_short;
		short_circuit && !ctrl_q.hiccup_retry_enable && state_q == bfc_pkg::ST_RUN;
	endsequence

	a_mask_blocks_irq: assert property (@(posedge mclk) disable iff (rst)
		ctrl_q.fault_irq_mask |=> interrupt_out_n)
		else $error("masked fault drove interrupt low");
	a_irq_on_fault: assert property (@(posedge mclk) disable iff (rst)
		(fault_q && !ctrl_q.fault_irq_mask) |=> !interrupt_out_n)
		else $error("unmasked fault gave no interrupt");
	a_hiccup_entry: assert property (@(posedge mclk) disable iff (rst)
		(short_circuit && ctrl_q.hiccup_retry_enable && state_q == bfc_pkg::ST_RUN)
		|=> state_q == bfc_pkg::ST_HICCUP)
		else $error("hiccup not entered on short");
	a_hiccup_local: assert property (@(posedge mclk) disable iff (rst)
		state_q == bfc_pkg::ST_HICCUP |-> !all_channels_off)
		else $error("hiccup shut other channels");
	a_global_off: assert property (@(posedge mclk) disable iff (rst)
		s_global_short |=> all_channels_off ##1 all_channels_off)
		else $error("global shutdown not raised");
	a_discharge_off: assert property (@(posedge mclk) disable iff (rst)
		(!ctrl_q.discharge_enable) |=> !discharge_on)
		else $error("discharge applied while disabled");
	a_phase_follow: assert property (@(posedge mclk) disable iff (rst)
		$changed(ctrl_q.phase_invert) |=> phase_180 == $past(ctrl_q.phase_invert))
		else $error("phase output not following bit");
	a_override_off: assert property (@(posedge mclk) disable iff (rst)
		(ctrl_q.register_on_override && !ctrl_q.register_enable) |=> !chan_on)
		else $error("channel on with register enable low");
	a_ignore_regen: assert property (@(posedge mclk) disable iff (rst)
		(!ctrl_q.register_on_override && !seq_enable) |=> !chan_on)
		else $error("register enable used without override");

	// ----------------------------------------
	// checks: enable source and discharge
	// ----------------------------------------
	// a short pulls the channel off, so only a quiet run is looked at
	sequence s_reg_on;
		state_q == bfc_pkg::ST_RUN && !short_circuit
		&& ctrl_q.register_on_override && ctrl_q.register_enable;
	endsequence
	sequence s_seq_on;
		state_q == bfc_pkg::ST_RUN && !short_circuit
		&& !ctrl_q.register_on_override && seq_enable;
	endsequence

	a_override_on: assert property (@(posedge mclk) disable iff (rst)
		s_reg_on |=> chan_on)
		else $error("channel off with register enable high");
	a_sequencer_on: assert property (@(posedge mclk) disable iff (rst)
		s_seq_on |=> chan_on)
		else $error("sequencer enable not followed");
	a_discharge_when_off: assert property (@(posedge mclk) disable iff (rst)
		ctrl_q.discharge_enable |=> discharge_on == !chan_on)
		else $error("discharge not tied to channel off");

	// ----------------------------------------
	// checks: fault reaction
	// ----------------------------------------
	// retries go on while the short lasts; there is no give-up count
	sequence s_hiccup_hold;
		state_q == bfc_pkg::ST_HICCUP && short_circuit
		&& ctrl_q.hiccup_retry_enable && want_on;
	endsequence
	// the pulse ends the shutdown in its own cycle and is low again one cycle later
	sequence s_restart_tail;
		!all_channels_off ##1 !restart_seq;
	endsequence

	a_hiccup_retry: assert property (@(posedge mclk) disable iff (rst)
		s_hiccup_hold |=> soft_start_req)
		else $error("soft start retry dropped during short");
	a_hiccup_no_off: assert property (@(posedge mclk) disable iff (rst)
		(state_q == bfc_pkg::ST_HICCUP && ctrl_q.hiccup_retry_enable)
		|=> !all_channels_off)
		else $error("hiccup raised global shutdown");
	a_restart_pulse: assert property (@(posedge mclk) disable iff (rst)
		restart_seq |-> s_restart_tail)
		else $error("restart pulse malformed");
	a_flag_on_short: assert property (@(posedge mclk) disable iff (rst)
		short_circuit |-> ##2 channel_fault_flag)
		else $error("fault flag not raised on short");
endmodule : bfc_top

//--- testbench/bfc_host.sv
// host model: byte writes and read addressing of the control register
`timescale 1ns/1ps
module bfc_host (
	// clock
	input wire logic mclk,
	// link request
	output bfc_pkg::bfc_wr_s req
);
	initial req = '0;
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1 req = '{wr: 1'b1, addr: a, wdata: d};
		@(posedge mclk);
		#1 req.wr = 1'b0;
	endtask : put
	task automatic peek(input logic [7:0] a);
		@(posedge mclk);
		#1 req.addr = a;
		@(posedge mclk);
		#1;
	endtask : peek
endmodule : bfc_host

//--- testbench/tb_bfc_top.sv
// testbench for the buck4 fault and control register block
`timescale 1ns/1ps
module tb_bfc_top;
	typedef struct {int s; logic [7:0] v;} bfc_note_s;
	// short restart delay keeps the run brief
	localparam int RESTART_SIM = 20;
	logic mclk, rst, short_circuit, seq_enable, soft_start_done;
	logic chan_on, soft_start_req, discharge_on, phase_180, all_channels_off;
	logic restart_seq, channel_fault_flag, interrupt_out_n;
	logic [7:0] reg_rdata;
	logic [1:0] scaling_rate, rate;
	bfc_pkg::bfc_wr_s req;
	int error_cnt = 0;
	int checks_done = 0;
	int i;
	bfc_note_s n;
	bfc_note_s exp_q[$];
	event look;
	string nm[10] = '{"rdata", "on", "disch", "phase", "rate", "alloff", "irq_n", "flag",
		"ssreq", "restart"};
	bfc_host bfc_host_i (.mclk(mclk), .req(req));
	bfc_top #(.RESTART_CYCLES(RESTART_SIM)) bfc_top_i (.mclk(mclk), .rst(rst), .reg_wr(req.wr),
		.reg_addr(req.addr), .reg_wdata(req.wdata), .reg_rdata(reg_rdata),
		.short_circuit(short_circuit), .seq_enable(seq_enable),
		.soft_start_done(soft_start_done), .chan_on(chan_on), .soft_start_req(soft_start_req),
		.discharge_on(discharge_on), .phase_180(phase_180), .scaling_rate(scaling_rate),
		.all_channels_off(all_channels_off), .restart_seq(restart_seq),
		.channel_fault_flag(channel_fault_flag), .interrupt_out_n(interrupt_out_n));
	// ----------------------------------------
	// scoreboard
	// ----------------------------------------
	function automatic logic [7:0] obs(input int s);
		case (s)
			0: return reg_rdata;
			1: return {7'h00, chan_on};
			2: return {7'h00, discharge_on};
			3: return {7'h00, phase_180};
			4: return {6'h00, scaling_rate};
			5: return {7'h00, all_channels_off};
			6: return {7'h00, interrupt_out_n};
			7: return {7'h00, channel_fault_flag};
			8: return {7'h00, soft_start_req};
			default: return {7'h00, restart_seq};
		endcase
	endfunction : obs
	task automatic note(input int s, input logic [7:0] v);
		exp_q.push_back('{s, v});
		->look;
		#0;
	endtask : note
	initial forever begin
		@(look);
		while (exp_q.size() > 0) begin
			n = exp_q.pop_front();
			checks_done++;
			if (obs(n.s) !== n.v) begin
				error_cnt++;
				$display("BAD %s exp %h got %h", nm[n.s], n.v, obs(n.s));
			end
		end
	end
	task automatic end_of_test();
		if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_of_test
	// write, then let the output edge pass
	task automatic wr(input logic [7:0] d);
		bfc_host_i.put(bfc_pkg::REG_OFFSET, d);
		@(posedge mclk);
		#1;
	endtask : wr
	// ----------------------------------------
	// stimulus
	// ----------------------------------------
	initial begin
		mclk = 0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		rst = 1;
		short_circuit = 0;
		seq_enable = 1;
		soft_start_done = 0;
		void'($urandom(32802));
		repeat (3) @(posedge mclk);
		#1 rst = 0;
		bfc_host_i.peek(8'h44);
		note(0, bfc_pkg::REG_RESET);
		bfc_host_i.peek(8'h45);
		note(0, 8'h00);
		wr(8'h03); note(1, 8'h01);
		wr(8'h01); note(1, 8'h00); note(2, 8'h00);
		wr(8'h20); note(1, 8'h01); note(2, 8'h00);
		wr(8'h21); note(2, 8'h01);
		rate = 2'($urandom());
		wr({4'h1, rate, 2'b00}); note(3, 8'h01); note(4, {6'h00, rate});
		wr(8'hC0); note(3, 8'h00);
		note(0, 8'hC0);
		short_circuit = 1;
		repeat (2) @(posedge mclk);
		#1 note(7, 8'h01); note(6, 8'h01);
		note(5, 8'h00); note(8, 8'h01);
		soft_start_done = 1;
		repeat (2) @(posedge mclk);
		#1 note(8, 8'h01); note(1, 8'h00);
		short_circuit = 0;
		repeat (3) @(posedge mclk);
		#1 soft_start_done = 0;
		wr(8'h00);
		short_circuit = 1;
		@(posedge mclk);
		#1 short_circuit = 0;
		@(posedge mclk);
		#1 note(5, 8'h01); note(6, 8'h00); note(1, 8'h00);
		for (i = 0; i < 40 && restart_seq !== 1'b1; i++) begin
			@(posedge mclk);
			#1;
		end
		// delay counts from the edge that took the short; a timeout fails here too
		checks_done++;
		if (i != RESTART_SIM - 1) begin
			error_cnt++;
			$display("BAD restart_delay exp %0d got %0d", RESTART_SIM - 1, i);
		end
		note(9, 8'h01);
		repeat (2) @(posedge mclk);
		#1 note(5, 8'h00);
		#1 end_of_test();
	end
endmodule : tb_bfc_top
